// File: bench/charger_host_i2c_status_test.sv
// Self-checking bench joining the charger target and its bus controller.
`timescale 1ns/1ns
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module charger_host_i2c_status_test import charger_pkg::*;;
  localparam int PULSE = 64;
  logic                   clock, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]             paddr, rb, ra;
  logic [31:0]            pwdata, prdata, rd;
  logic                   charging, indicator_enable, standalone_mode, battery_above_good;
  logic [EVENT_COUNT-1:0] charge_events;
  logic [2:0]             state_code, fault_code;
  logic                   watchdog_kick, supply_sel, hiz_request, nk, en, chg;
  integer                 failures = 0, total_checks = 0, kicks = 0, seed = 32'h530a;

  charger_if charger_if_i ();
  charger_target #(.PULSE_CYCLES(PULSE)) charger_target_i (
    .clock(clock), .sys_rst(sys_rst), .io(charger_if_i), .charging(charging),
    .indicator_enable(indicator_enable), .charge_events(charge_events),
    .state_code(state_code), .fault_code(fault_code), .standalone_mode(standalone_mode),
    .battery_above_good(battery_above_good), .watchdog_kick(watchdog_kick),
    .supply_sel(supply_sel), .hiz_request(hiz_request));
  charger_controller charger_controller_i (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io(charger_if_i));
  charger_link_checker #(.PULSE_CYCLES(PULSE)) charger_link_checker_i (
    .clock(clock), .sys_rst(sys_rst), .scl(charger_if_i.scl),
    .dev_sda_oe(charger_if_i.dev_sda_oe), .stat_oe(charger_if_i.stat_oe),
    .alert_oe(charger_if_i.alert_oe), .charging(charging),
    .indicator_enable(indicator_enable), .charge_events(charge_events),
    .watchdog_kick(watchdog_kick), .standalone_mode(standalone_mode),
    .battery_above_good(battery_above_good), .hiz_request(hiz_request));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) if (watchdog_kick === 1'b1) kicks++;

  // Battery and mode flags wander freely; the checker follows them.
  always @(posedge clock) begin
    standalone_mode <= 1'($random(seed));
    battery_above_good <= 1'($random(seed));
  end

  function automatic logic [7:0] reg0(input logic [2:0] s, input logic sel, input logic [2:0] f);
    return {1'b0, s, sel, f};
  endfunction : reg0

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n > 50) begin
        failures++;
        final_report();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One controller transaction; the read byte and the missing-ack flag come back.
  task automatic xfer(input logic rdn, input logic fast, input logic [7:0] r, input logic [7:0] w);
    int n;
    apb(1'b1, APB_REG_ADDR, {24'h0, r});
    apb(1'b1, APB_WDATA, {24'h0, w});
    apb(1'b1, APB_CTRL, {29'h0, fast, rdn, 1'b1});
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
      if (n > 8000) begin
        failures++;
        final_report();
      end
    end while (rd[0] !== 1'b0);
    rb = rd[15:8];
    nk = rd[1];
    `CHECK(nk, 1'b0)
  endtask : xfer

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    charging = 1'b0;
    indicator_enable = 1'b0;
    charge_events = '0;
    state_code = 3'h0;
    fault_code = 3'h0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    `CHECK(supply_sel, SUPPLY_SEL_RESET)
    charging <= 1'b1;
    indicator_enable <= 1'b1;
    repeat (3) @(posedge clock);
    `CHECK(charger_if_i.stat_line, 1'b0)
    `CHECK(charger_if_i.alert_line, 1'b0)
    apb(1'b0, APB_STATUS, 32'h0);
    `CHECK(rd[3:2], 2'b00)
    indicator_enable <= 1'b0;
    repeat (3) @(posedge clock);
    `CHECK(charger_if_i.stat_line, 1'b1)
    for (int i = 0; i < EVENT_COUNT; i++) begin
      en = 1'($random(seed));
      chg = 1'($random(seed));
      indicator_enable <= en;
      charging <= chg;
      charge_events <= EVENT_COUNT'(1 << i);
      @(posedge clock);
      charge_events <= '0;
      repeat (2) @(posedge clock);
      `CHECK(charger_if_i.stat_line, 1'b0)
      `CHECK(charger_if_i.alert_line, 1'b0)
      repeat (PULSE) @(posedge clock);
      `CHECK(charger_if_i.stat_line, !(chg && en))
    end
    // The slow rate once: kick plus supply select.
    xfer(DIR_WRITE, 1'b0, REG_STATUS_CONTROL, 8'h88);
    `CHECK(kicks, 1)
    `CHECK(supply_sel, 1'b1)
    // Every state and fault code; a latch not cleared by the read shows next round.
    for (int k = 0; k < 8; k++) begin
      state_code <= 3'(k);
      fault_code <= 3'(k);
      repeat (2) @(posedge clock);
      fault_code <= FAULT_NORMAL;
      xfer(DIR_READ, 1'b1, REG_STATUS_CONTROL, 8'h00);
      `CHECK(rb, reg0(3'(k), 1'b1, 3'(k)))
    end
    // First fault wins, and a read cannot clear a fault still present.
    fault_code <= 3'h3;
    repeat (2) @(posedge clock);
    fault_code <= 3'h6;
    xfer(DIR_READ, 1'b1, REG_STATUS_CONTROL, 8'h00);
    `CHECK(rb[2:0], 3'h3)
    fault_code <= FAULT_NORMAL;
    xfer(DIR_READ, 1'b1, REG_STATUS_CONTROL, 8'h00);
    `CHECK(rb[2:0], 3'h3)
    xfer(DIR_READ, 1'b1, REG_STATUS_CONTROL, 8'h00);
    `CHECK(rb[2:0], FAULT_NORMAL)
    ra = 8'($random(seed));
    if (ra == 8'h00) ra = 8'h5A;
    xfer(DIR_READ, 1'b1, ra, 8'h00);
    `CHECK(rb, UNMAPPED_READ)
    xfer(DIR_WRITE, 1'b1, ra, 8'h80);
    `CHECK(kicks, 1)
    final_report();
  end
endmodule : charger_host_i2c_status_test

// File: bench/charger_link_asserts.sv
// Checker on the charger link wires and the target's core-side signals.
`timescale 1ns/1ns
module charger_link_checker import charger_pkg::*; #(
  parameter int PULSE_CYCLES = PULSE_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   sys_rst,
  // Link wires
  input wire logic                   scl,
  input wire logic                   dev_sda_oe,
  input wire logic                   stat_oe,
  input wire logic                   alert_oe,
  // Target core side
  input wire logic                   charging,
  input wire logic                   indicator_enable,
  input wire logic [EVENT_COUNT-1:0] charge_events,
  input wire logic                   watchdog_kick,
  input wire logic                   standalone_mode,
  input wire logic                   battery_above_good,
  input wire logic                   hiz_request
);
  logic [15:0] pulse_left;

  // Counting the pulse here keeps the long hold out of a repetition operator.
  // The indicator output enable sits one register stage behind this count.
  always_ff @(posedge clock) begin
    if (sys_rst) pulse_left <= 16'h0;
    else if (|charge_events) pulse_left <= 16'(PULSE_CYCLES);
    else if (pulse_left != 16'h0) pulse_left <= pulse_left - 16'h1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  alert_mirror_a: assert property (alert_oe == stat_oe)
    else $error("alert output differs from indicator");
  pulse_start_a: assert property (|charge_events |-> ##2 stat_oe)
    else $error("event did not start a pulse");
  pulse_hold_a: assert property (pulse_left != 16'h0 |=> stat_oe)
    else $error("event pulse ended early");
  steady_level_a: assert property (!$past(sys_rst) && $past(pulse_left) == 16'h0 &&
    $stable(charging) && $stable(indicator_enable) |-> stat_oe == (charging && indicator_enable))
    else $error("steady indicator level wrong");
  hiz_follow_a: assert property (!$past(sys_rst) |-> hiz_request ==
    ($past(standalone_mode) && $past(battery_above_good)))
    else $error("high impedance request wrong");
  ack_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("target changed data while clock high");
  drive_rise_a: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("target took data line with clock high");
  drive_fall_a: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("target released data line with clock high");
  kick_single_a: assert property (watchdog_kick |=> !watchdog_kick)
    else $error("watchdog kick longer than one cycle");
endmodule : charger_link_checker

// File: pkg/charger_if.sv
// Open-drain bus and indicator wires joining the charger target and its controller.
`timescale 1ns/1ns
interface charger_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic stat_o;
  logic stat_oe;
  logic alert_o;
  logic alert_oe;
  logic scl;
  logic sda;
  logic stat_line;
  logic alert_line;

  // Pull-ups: a line is low only while some driver enables a low.
  assign scl        = !(host_scl_oe && !host_scl_o);
  assign sda        = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  assign stat_line  = !(stat_oe && !stat_o);
  assign alert_line = !(alert_oe && !alert_o);

  modport device (
    input  scl, sda,
    output dev_sda_o, dev_sda_oe, stat_o, stat_oe, alert_o, alert_oe
  );
  modport host (
    input  sda, stat_line, alert_line,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe
  );
endinterface : charger_if

// File: pkg/charger_pkg.sv
// Shared constants and types for the charger I2C target and its bus controller.
// Notes on behaviour
// - Indicator low while charging, if enabled
// - Indicator released when not charging
// - Each event gives one 128 us low pulse
// - Event pulses ignore the indicator enable
// - Alert output mirrors the indicator output
// - Standalone: good battery forces high impedance
// - Host mode ignores the good battery flag
// - Target only, 100 and 400 kbps
// - Seven-bit address 6B only
// - Acknowledge address only on a match
// - Eight data bits plus receiver acknowledge
// - Unimplemented register reads return FF
// - Controller ends aborted transfers with stop
// - Start and stop detected while SCL high
// - Controller keeps SDA stable while SCL high
// - Watchdog kick bit self-clears, reads zero
// - State code in bits six to four
// - Bit three selects supply precedence
// - Error code in bits two to zero
// - Error holds first fault, clears on read; a read while the fault is still present leaves it set
package charger_pkg;

  localparam int CLOCK_HZ  = 50_000_000;
  localparam int CLOCK_MHZ = CLOCK_HZ / 1_000_000;

  localparam int PULSE_TIME_US        = 128;
  localparam int PULSE_CYCLES_DEFAULT = PULSE_TIME_US * CLOCK_MHZ;
  localparam int PULSE_W              = 16;

  localparam int STD_RATE_BPS  = 100_000;
  localparam int FAST_RATE_BPS = 400_000;
  localparam int QUARTER_STD   = (CLOCK_HZ + 4 * STD_RATE_BPS - 1) / (4 * STD_RATE_BPS);
  localparam int QUARTER_FAST  = (CLOCK_HZ + 4 * FAST_RATE_BPS - 1) / (4 * FAST_RATE_BPS);
  localparam int QUARTER_W     = 8;

  localparam logic [6:0] TARGET_ADDR   = 7'h6B;
  localparam logic       DIR_WRITE     = 1'b0;
  localparam logic       DIR_READ      = 1'b1;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;

  localparam logic [7:0] REG_STATUS_CONTROL = 8'h00;
  localparam int         KICK_BIT           = 7;
  localparam int         SUPPLY_SEL_BIT     = 3;
  localparam logic       SUPPLY_SEL_RESET   = 1'b0;

  localparam int EVENT_COUNT = 7;

  localparam logic [2:0] FAULT_NORMAL = 3'h0;

  localparam logic [7:0] APB_CTRL     = 8'h00;
  localparam logic [7:0] APB_REG_ADDR = 8'h04;
  localparam logic [7:0] APB_WDATA    = 8'h08;
  localparam logic [7:0] APB_STATUS   = 8'h0C;
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int CTRL_FAST_BIT = 2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA
  } target_state_t;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} ctrl_state_t;

endpackage : charger_pkg

// File: verilog/charger_controller.sv
// I2C bus controller for the charger, ordered by software over APB.
`timescale 1ns/1ns
module charger_controller import charger_pkg::*; (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus pins
  charger_if.host          io
);

  logic [1:0]           sda_s;
  logic [1:0]           stat_s;
  logic [1:0]           alert_s;
  ctrl_state_t          state;
  logic [1:0]           quarter;
  logic [QUARTER_W-1:0] qcnt;
  logic                 tick;
  logic [3:0]           bit_idx;
  logic [1:0]           byte_idx;
  logic [8:0]           tx9;
  logic [7:0]           rx;
  logic                 busy;
  logic                 nack;
  logic                 rd_mode;
  logic                 fast;
  logic [7:0]           reg_addr;
  logic [7:0]           wdata;
  logic [7:0]           rdata;
  logic                 go;
  logic                 apb_write;
  logic                 last_byte;

  function automatic logic [8:0] frame(input logic [1:0] idx, input logic rd,
                                       input logic [7:0] ra, input logic [7:0] wd);
    case (idx)
      2'd0:    frame = {TARGET_ADDR, DIR_WRITE, 1'b1};
      2'd1:    frame = {ra, 1'b1};
      2'd2:    frame = rd ? {TARGET_ADDR, DIR_READ, 1'b1} : {wd, 1'b1};
      default: frame = 9'h1FF;
    endcase
  endfunction : frame

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sda_s   <= 2'h3;
      stat_s  <= 2'h3;
      alert_s <= 2'h3;
    end else begin
      sda_s   <= {sda_s[0], io.sda};
      stat_s  <= {stat_s[0], io.stat_line};
      alert_s <= {alert_s[0], io.alert_line};
    end
  end

  assign apb_write = psel && penable && pready && pwrite;
  assign go        = apb_write && paddr == APB_CTRL && pwdata[CTRL_GO_BIT] && !busy;
  assign last_byte = rd_mode ? (byte_idx == 2'd3) : (byte_idx == 2'd2);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (paddr == APB_REG_ADDR) begin
        prdata <= {24'h000000, reg_addr};
      end else if (paddr == APB_WDATA) begin
        prdata <= {24'h000000, wdata};
      end else if (paddr == APB_STATUS) begin
        prdata <= {16'h0000, rdata, 4'h0, alert_s[1], stat_s[1], nack, busy};
      end else if (paddr == APB_CTRL) begin
        prdata <= {29'h0, fast, rd_mode, 1'b0};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_addr <= 8'h00;
      wdata    <= 8'h00;
      rd_mode  <= 1'b0;
      fast     <= 1'b0;
    end else if (apb_write && !busy) begin
      if (paddr == APB_REG_ADDR) begin
        reg_addr <= pwdata[7:0];
      end else if (paddr == APB_WDATA) begin
        wdata <= pwdata[7:0];
      end else if (paddr == APB_CTRL) begin
        rd_mode <= pwdata[CTRL_READ_BIT];
        fast    <= pwdata[CTRL_FAST_BIT];
      end
    end
  end

  // Quarter-period timebase for SCL.
  always_ff @(posedge clock) begin
    if (sys_rst || state == H_IDLE || tick) begin
      qcnt <= '0;
    end else begin
      qcnt <= qcnt + QUARTER_W'(1);
    end
  end
  assign tick = qcnt == (fast ? QUARTER_W'(QUARTER_FAST - 1) : QUARTER_W'(QUARTER_STD - 1));

  // Data bits change only in the first quarter, while SCL is low; start and stop move SDA in the third quarter, with SCL high.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state    <= H_IDLE;
      quarter  <= 2'd0;
      bit_idx  <= 4'h0;
      byte_idx <= 2'd0;
      tx9      <= 9'h1FF;
      rx       <= 8'h00;
      busy     <= 1'b0;
      nack     <= 1'b0;
      rdata    <= 8'h00;
      io.host_scl_oe <= 1'b0;
      io.host_sda_oe <= 1'b0;
    end else if (state == H_IDLE) begin
      if (go) begin
        state    <= H_START;
        quarter  <= 2'd0;
        byte_idx <= 2'd0;
        busy     <= 1'b1;
        nack     <= 1'b0;
      end
    end else if (tick) begin
      quarter <= quarter + 2'd1;
      case (state)
        H_START: begin
          case (quarter)
            2'd0: io.host_sda_oe <= 1'b0;
            2'd1: io.host_scl_oe <= 1'b0;
            2'd2: io.host_sda_oe <= 1'b1;
            default: begin
              io.host_scl_oe <= 1'b1;
              state   <= H_BIT;
              bit_idx <= 4'h0;
              tx9     <= frame(byte_idx, rd_mode, reg_addr, wdata);
            end
          endcase
        end
        H_BIT: begin
          case (quarter)
            2'd0: io.host_sda_oe <= ~tx9[8];
            2'd1: io.host_scl_oe <= 1'b0;
            2'd2: begin
              rx  <= (bit_idx < 4'h8) ? {rx[6:0], sda_s[1]} : rx;
              tx9 <= (bit_idx == 4'h8 && byte_idx != 2'd3 && sda_s[1]) ? 9'h000 : tx9;
            end
            default: begin
              io.host_scl_oe <= 1'b1;
              tx9     <= {tx9[7:0], 1'b1};
              bit_idx <= bit_idx + 4'h1;
              if (bit_idx == 4'h8) begin
                if (tx9 == 9'h000) begin
                  nack  <= 1'b1;
                  state <= H_STOP;
                end else if (last_byte) begin
                  rdata <= rx;
                  state <= H_STOP;
                end else if (rd_mode && byte_idx == 2'd1) begin
                  byte_idx <= 2'd2;
                  state    <= H_START;
                end else begin
                  byte_idx <= byte_idx + 2'd1;
                  bit_idx  <= 4'h0;
                  tx9      <= frame(byte_idx + 2'd1, rd_mode, reg_addr, wdata);
                end
              end
            end
          endcase
        end
        default: begin
          case (quarter)
            2'd0: io.host_sda_oe <= 1'b1;
            2'd1: io.host_scl_oe <= 1'b0;
            2'd2: io.host_sda_oe <= 1'b0;
            default: begin
              state <= H_IDLE;
              busy  <= 1'b0;
            end
          endcase
        end
      endcase
    end
  end

  assign io.host_scl_o = 1'b0;
  assign io.host_sda_o = 1'b0;

endmodule : charger_controller

// File: verilog/charger_target.sv
// Charger I2C target, status/control register and indicator outputs.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
module charger_target import charger_pkg::*; #(
  parameter int PULSE_CYCLES = PULSE_CYCLES_DEFAULT
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Bus and indicator pins
  charger_if.device        io,
  // Charger core status
  input  wire logic        charging,
  input  wire logic        indicator_enable,
  input  wire logic [EVENT_COUNT-1:0] charge_events,
  input  wire logic [2:0]  state_code,
  input  wire logic [2:0]  fault_code,
  input  wire logic        standalone_mode,
  input  wire logic        battery_above_good,
  // Charger core control
  output logic             watchdog_kick,
  output logic             supply_sel,
  output logic             hiz_request
);

  logic [2:0]      scl_s;
  logic [2:0]      sda_s;
  logic            sda_now;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_seen;
  logic            stop_seen;
  target_state_t   state;
  logic [3:0]      bits;
  logic            in_ack;
  logic [7:0]      shift;
  logic [7:0]      tx;
  logic [7:0]      ptr;
  logic            read_dir;
  logic            host_nack;
  logic            sda_oe;
  logic            write_pulse;
  logic            read_clear;
  logic [2:0]      fault_latched;
  logic [7:0]      read_byte;
  logic [PULSE_W-1:0] pulse_cnt;
  logic            stat_drive;
  logic            load_read;

  function automatic logic [7:0] read_value(input logic [7:0] addr, input logic [2:0] st,
                                            input logic sel, input logic [2:0] flt);
    if (addr == REG_STATUS_CONTROL) begin
      read_value = {1'b0, st, sel, flt};
    end else begin
      read_value = UNMAPPED_READ;
    end
  endfunction : read_value

  // Only the second and third stages are looked at; the first only feeds the second.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], io.scl};
      sda_s <= {sda_s[1:0], io.sda};
    end
  end

  assign sda_now    = sda_s[1];
  assign scl_rise   = scl_s[1] && !scl_s[2];
  assign scl_fall   = !scl_s[1] && scl_s[2];
  assign start_seen = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
  assign stop_seen  = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];

  assign read_byte = read_value(ptr, state_code, supply_sel, fault_latched);
  assign load_read = (state == ST_ADDR && read_dir == DIR_READ) ||
                     (state == ST_RDATA && !host_nack);

  // Byte engine. Timing follows only the controller's SCL, so 100 and 400 kbps
  // look the same here; the sampling clock must stay well above four times SCL.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state       <= ST_IDLE;
      bits        <= 4'h0;
      in_ack      <= 1'b0;
      shift       <= 8'h00;
      tx          <= 8'h00;
      ptr         <= 8'h00;
      read_dir    <= DIR_WRITE;
      host_nack   <= 1'b0;
      sda_oe      <= 1'b0;
      write_pulse <= 1'b0;
      read_clear  <= 1'b0;
    end else begin
      write_pulse <= 1'b0;
      read_clear  <= 1'b0;
      if (start_seen) begin
        state  <= ST_ADDR;
        bits   <= 4'h0;
        in_ack <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state  <= ST_IDLE;
        in_ack <= 1'b0;
        sda_oe <= 1'b0;
      end else if (state != ST_IDLE && state != ST_WAIT) begin
        if (scl_rise) begin
          if (!in_ack) begin
            shift <= {shift[6:0], sda_now};
            bits  <= bits + 4'h1;
          end else if (state == ST_RDATA) begin
            host_nack <= sda_now;
          end
        end else if (scl_fall) begin
          if (!in_ack && bits == 4'h8) begin
            in_ack <= 1'b1;
            case (state)
              ST_ADDR: begin
                if (shift[7:1] == TARGET_ADDR) begin
                  sda_oe   <= 1'b1;
                  read_dir <= shift[0];
                end else begin
                  state <= ST_WAIT;
                end
              end
              ST_REG: begin
                sda_oe <= 1'b1;
                ptr    <= shift;
              end
              ST_WDATA: begin
                sda_oe      <= 1'b1;
                write_pulse <= (ptr == REG_STATUS_CONTROL);
                ptr         <= ptr + 8'h01;
              end
              default: begin
                sda_oe <= 1'b0;
                ptr    <= ptr + 8'h01;
              end
            endcase
          end else if (!in_ack && state == ST_RDATA) begin
            sda_oe <= ~tx[7];
            tx     <= {tx[6:0], 1'b0};
          end else if (in_ack) begin
            in_ack <= 1'b0;
            bits   <= 4'h0;
            if (load_read) begin
              state      <= ST_RDATA;
              sda_oe     <= ~read_byte[7];
              tx         <= {read_byte[6:0], 1'b0};
              read_clear <= (ptr == REG_STATUS_CONTROL);
            end else begin
              sda_oe <= 1'b0;
              case (state)
                ST_ADDR:  state <= ST_REG;
                ST_REG:   state <= ST_WDATA;
                ST_WDATA: state <= ST_WDATA;
                default:  state <= ST_WAIT;
              endcase
            end
          end
        end
      end
    end
  end

  // Bit seven is never stored, so the kick is a single pulse and reads zero.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      watchdog_kick <= 1'b0;
      supply_sel    <= SUPPLY_SEL_RESET;
    end else begin
      watchdog_kick <= write_pulse && shift[KICK_BIT];
      if (write_pulse) begin
        supply_sel <= shift[SUPPLY_SEL_BIT];
      end
    end
  end

  // A fault arriving with the clearing read keeps the code set.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fault_latched <= FAULT_NORMAL;
    end else if (fault_latched == FAULT_NORMAL) begin
      fault_latched <= fault_code;
    end else if (read_clear && fault_code == FAULT_NORMAL) begin
      fault_latched <= FAULT_NORMAL;
    end
  end

  // A new event during a pulse restarts it rather than stretching a queue.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pulse_cnt <= '0;
    end else if (|charge_events) begin
      pulse_cnt <= PULSE_W'(PULSE_CYCLES);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - PULSE_W'(1);
    end
  end

  assign stat_drive = (pulse_cnt != '0) || (charging && indicator_enable);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      io.stat_oe  <= 1'b0;
      io.alert_oe <= 1'b0;
      hiz_request <= 1'b0;
    end else begin
      io.stat_oe  <= stat_drive;
      io.alert_oe <= stat_drive;
      hiz_request <= standalone_mode && battery_above_good;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      io.dev_sda_oe <= 1'b0;
      io.dev_sda_o  <= 1'b0;
      io.stat_o     <= 1'b0;
      io.alert_o    <= 1'b0;
    end else begin
      io.dev_sda_oe <= sda_oe;
      io.dev_sda_o  <= 1'b0;
      io.stat_o     <= 1'b0;
      io.alert_o    <= 1'b0;
    end
  end

endmodule : charger_target
